/* verilog/acs_params.svh */
/*
 * Constants of the converter register bank and of its serial host:
 * register offsets, field positions, reset values and link timing.
 * Assumes it is included by bare name from files that need them.
 */
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

// ************************************************************
// Serial frame layout
// ************************************************************
`define ACS_INS_BITS       16
`define ACS_DAT_BITS       8
`define ACS_INS_RW         15
`define ACS_INS_W_HI       14
`define ACS_INS_W_LO       13
`define ACS_W_STREAM       2'h3

// ************************************************************
// Device register offsets
// ************************************************************
`define ACS_ADR_PORT_CFG   13'h000
`define ACS_ADR_CHIP_IDENTIFIER    13'h001
`define ACS_ADR_GRADE      13'h002
`define ACS_ADR_CHAN_IDX   13'h005
`define ACS_ADR_PROG_LO    13'h008
`define ACS_ADR_PROG_HI    13'h018
`define ACS_ADR_XFER       13'h0ff
`define ACS_NPROG          17

// ************************************************************
// Field positions and reset values
// ************************************************************
`define ACS_CFG_LSB_HI     6
`define ACS_CFG_LSB_LO     1
`define ACS_CFG_SRST_HI    5
`define ACS_CFG_SRST_LO    2
`define ACS_CFG_FIXED      8'h18
`define ACS_CHAN_IDX_RST   8'hff
`define ACS_CH_A           0
`define ACS_CH_B           1
`define ACS_XFER_BIT       0
`define ACS_GRADE_LSB      4
`define ACS_PROG_RST       8'h00
`define ACS_MODES_IDX      0
`define ACS_MODES_RST      8'h80
`define ACS_VREF_IDX       16
`define ACS_VREF_RST       8'he0
`define ACS_LOCAL_MASK     17'h00021

// ************************************************************
// Host software registers and link timing
// ************************************************************
`define ACS_WB_CMD         4'h0
`define ACS_WB_WDATA       4'h4
`define ACS_WB_STAT        4'h8
`define ACS_CMD_READ       15
`define ACS_CMD_LSB        16
`define ACS_STAT_RD_LSB    8
`define ACS_CLK_NS         5
`define ACS_SCLK_HALF_NS   60
`define ACS_SCLK_HALF_CYC  (`ACS_SCLK_HALF_NS / `ACS_CLK_NS)

`endif

/* verilog/acs_pkg.sv */
/*
 * Types shared by both ends of the converter serial link.
 * Assumes acs_params.svh holds the numeric constants.
 */
`default_nettype none

package acs_pkg;
    typedef logic [12:0] acs_addr_t;
    typedef logic [7:0]  acs_byte_t;

    // Device frame phase, Gray along instruction, data, done
    typedef enum logic [1:0] {
        ACS_PH_INSTR = 2'b00,
        ACS_PH_DATA  = 2'b01,
        ACS_PH_DONE  = 2'b11
    } acs_phase_t;

    // Host engine states, Gray around the bit loop
    typedef enum logic [1:0] {
        ACS_H_IDLE = 2'b00,
        ACS_H_LOW  = 2'b01,
        ACS_H_HIGH = 2'b11,
        ACS_H_END  = 2'b10
    } acs_hstate_t;
endpackage : acs_pkg

`default_nettype wire

/* verilog/acs_spi_if.sv */
/*
 * Three-wire serial link between host and converter register bank.
 * Resolves the shared data wire from both output enables; an idle
 * wire reads high as if pulled up.
 */
`timescale 1ns/1ps
`default_nettype none

interface acs_spi_if;
    logic sclk;
    logic csb_n;
    logic host_sdio_o;
    logic host_sdio_oe;
    logic dev_sdio_o;
    logic dev_sdio_oe;
    logic sdio;

    assign sdio = host_sdio_oe ? host_sdio_o : (dev_sdio_oe ? dev_sdio_o : 1'b1);

    modport host (output sclk, output csb_n, output host_sdio_o, output host_sdio_oe, input sdio);
    modport dev  (input sclk, input csb_n, input sdio, output dev_sdio_o, output dev_sdio_oe);
endinterface : acs_spi_if

`default_nettype wire

/* verilog/acs_shift.sv */
/*
 * Shift register with selectable bit order and parallel load.
 * Assumes load and shift are never asked in the same cycle.
 */
`timescale 1ns/1ps
`default_nettype none

module acs_shift #(
    parameter int W = 8
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] load_val_i,
    input  wire logic         shift_i,
    input  wire logic         lsb_i,
    input  wire logic         ser_i,
    output logic      [W-1:0] par_o,
    output logic              ser_o
);
    logic [W-1:0] sr;

    assign par_o = sr;
    assign ser_o = lsb_i ? sr[0] : sr[W-1];

    always_ff @(posedge clk_i) begin
        if (rst_i)
            sr <= '0;
        else if (load_i)
            sr <= load_val_i;
        else if (shift_i)
            sr <= lsb_i ? {ser_i, sr[W-1:1]} : {sr[W-2:0], ser_i};
    end
endmodule : acs_shift

`default_nettype wire

/* verilog/acs_dev.sv */
/*
 * Converter end of the serial link: frame decoder, chip configuration
 * registers, channel index steering, shadowed program registers and
 * the transfer register that moves them into the active set.
 * Assumes the host keeps each serial clock half period long enough
 * for the three-stage pin synchronisers (see hand-over timing).
 */
// Design decision made here: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

// Functional notes
// - program register writes land in shadow copies
// - writing one to transfer copies shadows active
// - transfer bit clears itself after the copy
// - index bits steer local registers per channel
// - both index bits set writes both copies
// - read with both bits set returns channel A
// - global registers ignore the channel index
// - host writes zeros into unused bits
// - host never writes fully open addresses
// - reset loads default values everywhere
// - port configuration nibbles mirrored, default fixed
// - reference select resets to its default
// - sixteen bit instruction then byte data
// - most significant bit first until changed
module acs_dev #(
    parameter logic [7:0]            CHIP_IDENTIFIER    = 8'h5a, // Arbitrary value
    parameter logic [2:0]            GRADE_ID   = 3'h0,  // Arbitrary value
    parameter logic [`ACS_NPROG-1:0] LOCAL_MASK = `ACS_LOCAL_MASK
) (
    input  wire logic                    clk_i,
    input  wire logic                    rst_i,
    acs_spi_if.dev                       spi,
    output logic [`ACS_NPROG*8-1:0]      act_a_o,
    output logic [`ACS_NPROG*8-1:0]      act_b_o,
    output logic                         lsb_first_o,
    output logic [1:0]                   chan_sel_o,
    output logic                         xfer_o
);
    import acs_pkg::*;

    // ************************************************************
    // Pin synchronisers: {sclk, csb_n, sdio}
    // ************************************************************
    logic [2:0] pin1;
    logic [2:0] pin2;
    logic [2:0] pin3;
    logic [2:0] pinf;
    logic       sclk_d;
    wire  [2:0] next_pinf = (pin2 & pin3) | (pinf & (pin2 | pin3));
    wire        frame_off = pinf[1];
    wire        sdi       = pinf[0];
    wire        rise      = pinf[2] & ~sclk_d & ~frame_off;
    wire        fall      = ~pinf[2] & sclk_d & ~frame_off;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pin1   <= 3'h2;
            pin2   <= 3'h2;
            pin3   <= 3'h2;
            pinf   <= 3'h2;
            sclk_d <= 1'b0;
        end else begin
            pin1   <= {spi.sclk, spi.csb_n, spi.sdio};
            pin2   <= pin1;
            pin3   <= pin2;
            pinf   <= next_pinf;
            sclk_d <= pinf[2];
        end
    end

    // ************************************************************
    // Frame state
    // ************************************************************
    acs_phase_t phase;
    logic [3:0] bitc;
    logic       ins_done;
    logic       dat_done;
    logic       ld_rd;
    logic       fresh;
    logic       rd;
    logic [1:0] wlen;
    logic [1:0] bcnt;
    acs_addr_t  addr;
    logic       lsb;
    logic       oe;
    logic       sdo;
    logic [7:0] idx;
    logic       xfer;
    acs_byte_t  shad_a [`ACS_NPROG];
    acs_byte_t  shad_b [`ACS_NPROG];
    acs_byte_t  act_a  [`ACS_NPROG];
    acs_byte_t  act_b  [`ACS_NPROG];

    logic [15:0] ins_par;
    acs_byte_t   dat_par;
    logic        dat_ser;
    acs_byte_t   rd_val;

    wire in_ins    = (phase == ACS_PH_INSTR);
    wire in_dat    = (phase == ACS_PH_DATA);
    wire ins_shift = in_ins & rise;
    wire dat_shift = in_dat & ((~rd & rise) | (rd & fall & ~fresh));
    wire last_bit  = in_ins ? (bitc == 4'(`ACS_INS_BITS - 1)) : (bitc == 4'(`ACS_DAT_BITS - 1));

    // Instruction and data shifters share the frame's bit order
    acs_shift #(.W(`ACS_INS_BITS)) u_ins (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (1'b0),
        .load_val_i (16'h0000),
        .shift_i    (ins_shift),
        .lsb_i      (lsb),
        .ser_i      (sdi),
        .par_o      (ins_par),
        .ser_o      ()
    );

    acs_shift #(.W(`ACS_DAT_BITS)) u_dat (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .load_i     (ld_rd),
        .load_val_i (rd_val),
        .shift_i    (dat_shift),
        .lsb_i      (lsb),
        .ser_i      (sdi),
        .par_o      (dat_par),
        .ser_o      (dat_ser)
    );

    // ************************************************************
    // Decode of the register written at the end of a byte
    // ************************************************************
    wire        wr       = dat_done & ~rd;
    wire        in_prog  = (addr >= `ACS_ADR_PROG_LO) && (addr <= `ACS_ADR_PROG_HI);
    wire [4:0]  pidx     = 5'(addr - `ACS_ADR_PROG_LO);
    wire        is_local = in_prog && LOCAL_MASK[pidx];
    wire        wr_cfg   = wr && (addr == `ACS_ADR_PORT_CFG);
    wire        srst     = wr_cfg && (dat_par[`ACS_CFG_SRST_HI] | dat_par[`ACS_CFG_SRST_LO]);
    wire        clr      = rst_i | srst;
    wire        wr_idx   = wr && (addr == `ACS_ADR_CHAN_IDX);
    wire        wr_xfer  = wr && (addr == `ACS_ADR_XFER) && dat_par[`ACS_XFER_BIT];
    // Global program registers keep both copies equal
    wire        wr_a     = wr && in_prog && (~is_local | idx[`ACS_CH_A]);
    wire        wr_b     = wr && in_prog && (~is_local | idx[`ACS_CH_B]);
    wire        rd_b     = is_local & ~idx[`ACS_CH_A] & idx[`ACS_CH_B];
    wire [7:0]  cfg_val  = `ACS_CFG_FIXED | ({7'h00, lsb} << `ACS_CFG_LSB_HI)
                         | ({7'h00, lsb} << `ACS_CFG_LSB_LO);
    wire        dn_last  = (wlen != `ACS_W_STREAM) && (bcnt == wlen);
    acs_addr_t  next_addr;

    assign next_addr = lsb ? 13'(addr + 13'h0001) : 13'(addr - 13'h0001);
    assign rd_val = (addr == `ACS_ADR_PORT_CFG) ? cfg_val :
                    (addr == `ACS_ADR_CHIP_IDENTIFIER)  ? CHIP_IDENTIFIER :
                    (addr == `ACS_ADR_GRADE)    ? 8'({GRADE_ID, 4'h0}) :
                    (addr == `ACS_ADR_CHAN_IDX) ? idx :
                    (addr == `ACS_ADR_XFER)     ? {7'h00, xfer} :
                    in_prog ? (rd_b ? shad_b[pidx] : shad_a[pidx]) : 8'h00;

    // ************************************************************
    // Frame sequencing; a raised chip select ends every frame
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i || frame_off) begin
            phase    <= ACS_PH_INSTR;
            bitc     <= 4'h0;
            ins_done <= 1'b0;
            dat_done <= 1'b0;
            ld_rd    <= 1'b0;
            fresh    <= 1'b0;
            rd       <= 1'b0;
            wlen     <= 2'h0;
            bcnt     <= 2'h0;
            addr     <= 13'h0000;
            oe       <= 1'b0;
        end else begin
            ins_done <= ins_shift & last_bit;
            dat_done <= in_dat & rise & last_bit;
            ld_rd    <= (ins_done & ins_par[`ACS_INS_RW]) | (dat_done & rd);
            if (rise && !(phase == ACS_PH_DONE)) begin
                bitc <= last_bit ? 4'h0 : 4'(bitc + 4'h1);
                if (in_ins && last_bit)
                    phase <= ACS_PH_DATA;
            end
            if (ins_done) begin
                rd   <= ins_par[`ACS_INS_RW];
                wlen <= ins_par[`ACS_INS_W_HI:`ACS_INS_W_LO];
                addr <= ins_par[12:0];
            end
            if (dat_done) begin
                addr <= next_addr;
                bcnt <= 2'(bcnt + 2'h1);
                if (dn_last)
                    phase <= ACS_PH_DONE;
            end
            if (ld_rd)
                fresh <= 1'b1;
            else if (fall)
                fresh <= 1'b0;
            if (fall)
                oe <= in_dat & rd;
        end
    end

    // ************************************************************
    // Registers; a soft reset restores the same defaults as rst_i
    // ************************************************************
    always_ff @(posedge clk_i) begin
        // Reply only moves while the clock is low, so a reload never shows mid-bit
        if (!pinf[2])
            sdo <= dat_ser;
        if (clr) begin
            lsb  <= 1'b0;
            idx  <= `ACS_CHAN_IDX_RST;
            xfer <= 1'b0;
            for (int i = 0; i < `ACS_NPROG; i++) begin
                shad_a[i] <= `ACS_PROG_RST;
                shad_b[i] <= `ACS_PROG_RST;
                act_a[i]  <= `ACS_PROG_RST;
                act_b[i]  <= `ACS_PROG_RST;
            end
            shad_a[`ACS_MODES_IDX] <= `ACS_MODES_RST;
            shad_b[`ACS_MODES_IDX] <= `ACS_MODES_RST;
            act_a[`ACS_MODES_IDX]  <= `ACS_MODES_RST;
            act_b[`ACS_MODES_IDX]  <= `ACS_MODES_RST;
            shad_a[`ACS_VREF_IDX]  <= `ACS_VREF_RST;
            shad_b[`ACS_VREF_IDX]  <= `ACS_VREF_RST;
            act_a[`ACS_VREF_IDX]   <= `ACS_VREF_RST;
            act_b[`ACS_VREF_IDX]   <= `ACS_VREF_RST;
        end else begin
            if (wr_cfg)
                lsb <= dat_par[`ACS_CFG_LSB_HI] | dat_par[`ACS_CFG_LSB_LO];
            if (wr_idx)
                idx <= dat_par;
            if (wr_a)
                shad_a[pidx] <= dat_par;
            if (wr_b)
                shad_b[pidx] <= dat_par;
            // A fresh transfer write wins over the self clear
            xfer <= wr_xfer;
            if (xfer) begin
                for (int i = 0; i < `ACS_NPROG; i++) begin
                    act_a[i] <= shad_a[i];
                    act_b[i] <= shad_b[i];
                end
            end
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    for (genvar g = 0; g < `ACS_NPROG; g++) begin : g_act
        assign act_a_o[g*8 +: 8] = act_a[g];
        assign act_b_o[g*8 +: 8] = act_b[g];
    end

    assign lsb_first_o     = lsb;
    assign chan_sel_o      = idx[`ACS_CH_B:`ACS_CH_A];
    assign xfer_o          = xfer;
    assign spi.dev_sdio_o  = sdo;
    assign spi.dev_sdio_oe = oe;
endmodule : acs_dev

`default_nettype wire

/* verilog/acs_host.sv */
/*
 * Host end of the serial link: a classic Wishbone slave whose command
 * register launches one single-byte read or write frame.
 * Assumes software tracks the device bit order and writes zeros into
 * open bits and never to open addresses.
 */
`timescale 1ns/1ps
`default_nettype none
`include "acs_params.svh"

module acs_host #(
    parameter int HALF = `ACS_SCLK_HALF_CYC
) (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    acs_spi_if.host          spi
);
    import acs_pkg::*;

    function automatic logic [15:0] rev16(input logic [15:0] v);
        logic [15:0] r;
        r = 16'h0000;
        for (int i = 0; i < 16; i++)
            r[i] = v[15-i];
        return r;
    endfunction : rev16

    // ************************************************************
    // Bus decode
    // ************************************************************
    acs_hstate_t state;
    logic [7:0]  cnt;
    logic [4:0]  bitn;
    logic [23:0] frame;
    logic        rd;
    logic        lsb;
    acs_byte_t   wdata;
    acs_byte_t   rdata;
    logic        sclk;
    logic        csb_n;
    logic        sdo;
    logic        oe;
    logic [2:0]  din;
    logic        dinf;

    wire         req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // Writes land at the edge that sees ack, as a classic master expects
    wire         take    = wb_cyc_i & wb_stb_i & wb_ack_o;
    wire         busy    = (state != ACS_H_IDLE);
    wire         wr_cmd  = take & wb_we_i & (wb_adr_i == `ACS_WB_CMD) & (wb_sel_i == 4'hf) & ~busy;
    wire         wr_wd   = take & wb_we_i & (wb_adr_i == `ACS_WB_WDATA) & wb_sel_i[0];
    wire         c_rd    = wb_dat_i[`ACS_CMD_READ];
    wire         c_lsb   = wb_dat_i[`ACS_CMD_LSB];
    // Write length field left at one byte
    wire  [15:0] instr   = {c_rd, 2'b00, wb_dat_i[12:0]};
    wire  [15:0] instr_r = rev16(instr);
    wire  [15:0] data_r  = rev16({8'h00, wdata});
    wire  [31:0] rd_word = (wb_adr_i == `ACS_WB_STAT) ?
                           (32'(rdata) << `ACS_STAT_RD_LSB) | {31'h0, busy} : 32'h0;
    wire         half_up = (cnt == 8'(HALF - 1));
    wire         capture = (state == ACS_H_LOW) & half_up & rd & (bitn >= 5'd16);
    wire         next_dinf = (din[1] & din[2]) | (dinf & (din[1] | din[2]));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
            wdata    <= 8'h00;
            din      <= 3'h7;
            dinf     <= 1'b1;
        end else begin
            wb_ack_o <= req;
            wb_dat_o <= req ? rd_word : wb_dat_o;
            din      <= {din[1:0], spi.sdio};
            dinf     <= next_dinf;
            if (wr_wd)
                wdata <= wb_dat_i[7:0];
        end
    end

    // ************************************************************
    // Frame engine: 16 instruction bits then 8 data bits
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ACS_H_IDLE;
            cnt   <= 8'h00;
            bitn  <= 5'h00;
            frame <= 24'h0;
            rd    <= 1'b0;
            lsb   <= 1'b0;
            rdata <= 8'h00;
            sclk  <= 1'b0;
            csb_n <= 1'b1;
            sdo   <= 1'b0;
            oe    <= 1'b0;
        end else begin
            cnt <= (state == ACS_H_IDLE || half_up) ? 8'h00 : 8'(cnt + 8'h01);
            if (capture)
                rdata <= lsb ? {dinf, rdata[7:1]} : {rdata[6:0], dinf};
            unique case (state)
                ACS_H_IDLE: begin
                    if (wr_cmd) begin
                        frame <= c_lsb ? {instr_r, data_r[15:8]} : {instr, wdata};
                        sdo   <= c_lsb ? instr_r[15] : instr[15];
                        rd    <= c_rd;
                        lsb   <= c_lsb;
                        bitn  <= 5'h00;
                        csb_n <= 1'b0;
                        oe    <= 1'b1;
                        state <= ACS_H_LOW;
                    end
                end
                ACS_H_LOW: begin
                    if (half_up) begin
                        sclk  <= 1'b1;
                        state <= ACS_H_HIGH;
                    end
                end
                ACS_H_HIGH: begin
                    if (half_up) begin
                        sclk <= 1'b0;
                        if (bitn == 5'd23) begin
                            oe    <= 1'b0;
                            state <= ACS_H_END;
                        end else begin
                            bitn  <= 5'(bitn + 5'h01);
                            frame <= {frame[22:0], 1'b0};
                            sdo   <= frame[22];
                            // Release the wire for the device's reply
                            oe    <= ~(rd && bitn >= 5'd15);
                            state <= ACS_H_LOW;
                        end
                    end
                end
                ACS_H_END: begin
                    if (half_up) begin
                        csb_n <= 1'b1;
                        state <= ACS_H_IDLE;
                    end
                end
            endcase
        end
    end

    assign spi.sclk         = sclk;
    assign spi.csb_n        = csb_n;
    assign spi.host_sdio_o  = sdo;
    assign spi.host_sdio_oe = oe;
endmodule : acs_host

`default_nettype wire

/* verif/acs_asserts.sv */
/* Wire-level checks of the serial link between host and converter.
   Assumes it is instantiated beside the link, with HALF from 8 to 14. */
`timescale 1ns/1ps
`default_nettype none

module acs_asserts (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic sclk,
    input wire logic csb_n,
    input wire logic host_sdio_o,
    input wire logic host_sdio_oe,
    input wire logic dev_sdio_o,
    input wire logic dev_sdio_oe
);
    // ********************************
    // Framing of the link
    // ********************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_open;
        $fell(csb_n);
    endsequence
    sequence s_still;
        !sclk [*8];
    endsequence
    chk_one_driver: assert property (!(host_sdio_oe && dev_sdio_oe))
        else $error("both ends drive the data wire");
    chk_clock_parked: assert property (csb_n |-> !sclk)
        else $error("serial clock moves outside a frame");
    // Device sees the select through synchronisers, so it may lag
    chk_dev_silent: assert property (csb_n && $past(csb_n, 4) |-> !dev_sdio_oe)
        else $error("device drives while deselected");
    chk_host_leads: assert property (s_open |-> host_sdio_oe && !sclk)
        else $error("host not driving at frame start");
    chk_lead_time: assert property (s_open |-> s_still)
        else $error("first clock edge too early");
    chk_high_phase: assert property ($rose(sclk) |-> sclk [*8])
        else $error("clock high phase too short");
    chk_low_phase: assert property ($fell(sclk) |-> s_still)
        else $error("clock low phase too short");
    chk_cmd_steady: assert property (sclk && $past(sclk) && host_sdio_oe |-> $stable(host_sdio_o))
        else $error("host data moves while clock high");
    chk_reply_steady: assert property (sclk && $past(sclk) && dev_sdio_oe |-> $stable(dev_sdio_o))
        else $error("device data moves while clock high");
    chk_frame_ends: assert property (s_open |-> ##[1:700] $rose(csb_n))
        else $error("frame never closes");
endmodule : acs_asserts

`default_nettype wire

/* verif/tb_adc_spi_register_map_shadowing.sv */
/* Bench joining host and converter ends over the serial link.
   Assumes the design files, package and link interface compile first. */
`timescale 1ns/1ps
`default_nettype none

module tb_adc_spi_register_map_shadowing;
    import acs_pkg::*;
    localparam logic [7:0] ID = 8'h3c; // Arbitrary value
    logic         clk_i, rst_i, cyc, stb, we, lsb_m, lsb_o, xfer_o, ack;
    logic [3:0]   adr;
    logic [31:0]  wdat, rdat, q;
    logic [135:0] act_a, act_b;
    logic [1:0]   chan;
    int           err_count, cmp_count, cyc_n, xn;
    acs_spi_if spi ();
    acs_host #(.HALF(12)) acs_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .spi(spi.host));
    acs_dev #(.CHIP_IDENTIFIER(ID)) acs_dev_i (.clk_i(clk_i), .rst_i(rst_i), .spi(spi.dev), .act_a_o(act_a),
        .act_b_o(act_b), .lsb_first_o(lsb_o), .chan_sel_o(chan), .xfer_o(xfer_o));
    acs_asserts acs_asserts_i (.clk_i(clk_i), .rst_i(rst_i), .sclk(spi.sclk), .csb_n(spi.csb_n),
        .host_sdio_o(spi.host_sdio_o), .host_sdio_oe(spi.host_sdio_oe), .dev_sdio_o(spi.dev_sdio_o),
        .dev_sdio_oe(spi.dev_sdio_oe));
    // ********************************
    // Bus and frame tasks
    // ********************************
    task automatic finish_test;
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        cmp_count++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
        end
    endtask : chk
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do @(posedge clk_i); while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask : wb
    // Status is polled, since a command while busy is dropped
    task automatic frame(input logic rd, input logic [12:0] a, input logic [7:0] d);
        wb(1'b1, 4'h4, {24'h0, d});
        wb(1'b1, 4'h0, {15'h0, lsb_m, rd, 2'h0, a});
        do wb(1'b0, 4'h8, 32'h0); while (q[0] !== 1'b0);
    endtask : frame
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        frame(1'b0, a, d);
    endtask : wr
    task automatic rdc(input logic [12:0] a, input logic [7:0] e);
        frame(1'b1, a, 8'h00);
        chk(q[15:8], e);
    endtask : rdc
    // ********************************
    // Scenarios
    // ********************************
    task automatic t_reset;
        chk(act_a[7:0], 8'h80);
        chk(act_b[135:128], 8'he0);
        chk({6'h0, chan}, 8'h03);
        chk({7'h0, lsb_o}, 8'h00);
        rdc(13'h000, 8'h18);
        rdc(13'h005, 8'hff);
        rdc(13'h018, 8'he0);
        wr(13'h001, ~ID);
        rdc(13'h001, ID);
        $display("test reset done");
    endtask : t_reset
    task automatic t_chan;
        wr(13'h005, 8'h01);
        wr(13'h00d, 8'h11);
        wr(13'h005, 8'h02);
        wr(13'h00d, 8'h22);
        rdc(13'h00d, 8'h22);
        wr(13'h005, 8'h03);
        wr(13'h008, 8'h44);
        rdc(13'h00d, 8'h11);
        chk(act_b[47:40], 8'h00);
        wr(13'h0ff, 8'h01);
        chk(act_a[47:40], 8'h11);
        chk(act_b[47:40], 8'h22);
        chk(act_a[7:0], 8'h44);
        chk(act_b[7:0], 8'h44);
        $display("test channels done");
    endtask : t_chan
    task automatic t_xfer;
        wr(13'h005, 8'h01);
        wr(13'h009, 8'h01);
        chk(act_b[15:8], 8'h00);
        rdc(13'h009, 8'h01);
        wr(13'h0ff, 8'h01);
        chk(act_a[15:8], 8'h01);
        chk(act_b[15:8], 8'h01);
        rdc(13'h0ff, 8'h00);
        chk(xn[7:0], 8'h02);
        $display("test transfer done");
    endtask : t_xfer
    // Both values below read the same in either shift order
    task automatic t_order;
        wr(13'h000, 8'h5a);
        lsb_m = 1'b1;
        chk({7'h0, lsb_o}, 8'h01);
        wr(13'h018, 8'hc0);
        rdc(13'h018, 8'hc0);
        rdc(13'h005, 8'h01);
        wr(13'h000, 8'h3c);
        lsb_m = 1'b0;
        chk({7'h0, lsb_o}, 8'h00);
        rdc(13'h018, 8'he0);
        rdc(13'h000, 8'h18);
        $display("test bit order done");
    endtask : t_order
    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc_n++;
        if (xfer_o === 1'b1) xn++;
        if (cyc_n == 40000) begin
            err_count++;
            finish_test();
        end
    end
    initial begin
        {rst_i, cyc, stb, we, lsb_m, adr, wdat} = {5'h10, 4'h0, 32'h0};
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        // Device pin synchronisers need a few cycles before a frame
        repeat (6) @(posedge clk_i);
        t_reset();
        t_chan();
        t_xfer();
        t_order();
        finish_test();
    end
endmodule : tb_adc_spi_register_map_shadowing

`default_nettype wire
